// ### rsc_pin_model.sv
// rsc_pin_model: the board side of the shared reset/port pin
// assumes one mclk; ext_low models an external party pulling the pin low
`timescale 1ns/1ps
module rsc_pin_model (
    input  wire logic mclk,
    input  wire logic ext_low,
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    input  wire logic pull_on,
    output logic      pin
);
    logic flo = 1'b0;
    // undriven and unpulled: a changing pattern so no settled value is trusted
    always @(posedge mclk) flo <= ~flo;
    assign pin = !pin_oe_n ? pin_out : ext_low ? 1'b0 : pull_on ? 1'b1 : flo;
endmodule

// ### rsc_pkg.sv
// rsc_pkg: constants shared by the reset source collector files
// assumes the system clock is 20 MHz
package rsc_pkg;
    localparam int          CAUSE_W        = 7;
    localparam int          CAUSE_POR      = 0;
    localparam int          CAUSE_PPD      = 1;
    localparam int          CAUSE_LVD      = 2;
    localparam int          CAUSE_EXT      = 3;
    localparam int          CAUSE_WD_LOR   = 4;
    localparam int          CAUSE_WD_TMO   = 5;
    localparam int          CAUSE_SW       = 6;
    localparam logic [6:0]  STATUS_RESET   = 7'h00;
    localparam int          PORTA_W        = 8;
    localparam int          SHARED_BIT     = 7;
    localparam logic [7:0]  PORTA_PER_INIT = 8'hFF;
    localparam logic [20:0] RESET_VECTOR   = 21'h000000;
    localparam int          CLK_HZ         = 20000000;
    localparam int          HOLD_NS        = 1000;
    localparam int          HOLD_CYCLES    = (HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
    typedef enum logic [1:0] {RSC_RUN, RSC_ASSERT, RSC_HOLD} rsc_state_e;
endpackage

// ### rsc_sync.sv
// rsc_sync: two-flop synchroniser for one asynchronous level
// assumes the input is a pin or detector output outside the mclk domain
`timescale 1ns/1ps
module rsc_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta;

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta     <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ### rsc_top.sv
// rsc_top: collects reset causes into one system reset, records them, owns the shared pin
// assumes detectors and the pin are asynchronous; software strobes are on mclk
`timescale 1ns/1ps
module rsc_top #(
    parameter int HOLD = rsc_pkg::HOLD_CYCLES
) (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    power_on_reset,
    input  wire logic                    partial_power_down_reset,
    input  wire logic                    low_voltage_detect_reset,
    input  wire logic                    watchdog_lost_reference_reset,
    input  wire logic                    watchdog_timeout_reset,
    input  wire logic                    software_request_reset,
    input  wire logic [6:0]              status_clear,
    input  wire logic                    porta_per_we,
    input  wire logic [7:0]              porta_per_wdata,
    input  wire logic                    gpio_a7_out,
    input  wire logic                    gpio_a7_drive,
    input  wire logic                    shared_pin_in,
    output logic                         shared_pin_out,
    output logic                         shared_pin_oe_n,
    output logic                         shared_pin_pullup,
    output logic                         gpio_a7_in,
    output logic [7:0]                   port_a_peripheral_enable,
    output logic [6:0]                   reset_cause_status,
    output logic                         system_reset,
    output logic                         peripheral_disable,
    output logic                         pins_to_reset_cfg,
    output logic                         pc_load,
    output logic [20:0]                  pc_reset_vector
);
    logic [6:0]          raw;
    logic [6:0]          cause;
    logic                pin_sync;
    logic                any_cause;
    logic                hold_cnt_done;
    logic [15:0]         hold_cnt;
    logic                pin_is_reset;
    logic                ext_cause;
    logic [1:0]          pull_age;
    // RUN is released; ASSERT follows an active cause; HOLD stretches after the last one
    rsc_pkg::rsc_state_e state;

    rsc_sync #(.RESET_VAL(1'b1)) u_pin (
        .mclk     (mclk),
        .rst      (rst),
        .async_in (shared_pin_in),
        .sync_out (pin_sync)
    );

    genvar g;
    generate
        for (g = 0; g < rsc_pkg::CAUSE_W; g++) begin : g_sync
            if (g == rsc_pkg::CAUSE_SW) begin : g_direct
                // software strobe is already on mclk
                assign cause[g] = raw[g];
            end else if (g == rsc_pkg::CAUSE_EXT) begin : g_pin
                // the pin has its own synchroniser, shared with the gpio input path
                assign cause[g] = ext_cause;
            end else begin : g_async
                rsc_sync #(.RESET_VAL(1'b0)) u_s (
                    .mclk     (mclk),
                    .rst      (rst),
                    .async_in (raw[g]),
                    .sync_out (cause[g])
                );
            end
        end
    endgenerate

    // the ext slot stays empty here: the pin joins after its own synchroniser
    always_comb begin
        raw                          = '0;
        raw[rsc_pkg::CAUSE_POR]      = power_on_reset;
        raw[rsc_pkg::CAUSE_PPD]      = partial_power_down_reset;
        raw[rsc_pkg::CAUSE_LVD]      = low_voltage_detect_reset;
        raw[rsc_pkg::CAUSE_WD_LOR]   = watchdog_lost_reference_reset;
        raw[rsc_pkg::CAUSE_WD_TMO]   = watchdog_timeout_reset;
        raw[rsc_pkg::CAUSE_SW]       = software_request_reset;
    end

    // pin is a reset source only while it holds its reset function; low is active
    assign pin_is_reset = port_a_peripheral_enable[rsc_pkg::SHARED_BIT];
    // the synchroniser still carries gpio-mode levels for a few edges after the
    // pull-up returns; a pin left low as gpio must not pose as an external reset
    assign ext_cause    = pin_is_reset & (&pull_age) & ~pin_sync;
    assign any_cause    = |cause;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pull_age <= 2'h3;
        end else begin
            pull_age <= {pull_age[0], shared_pin_pullup};
        end
    end

    // reset stretched so a one-cycle pulse still reaches every consumer;
    // HOLD must be at least 1, as the compare below wraps for zero
    assign hold_cnt_done = (hold_cnt >= 16'(HOLD - 1));

    // the stretch counter runs only in HOLD; a cause arriving there clears it,
    // so every new cause buys the full stretch again
    always_ff @(posedge mclk) begin
        if (rst || (state != rsc_pkg::RSC_HOLD) || any_cause) begin
            hold_cnt <= 16'h0000;
        end else if (!hold_cnt_done) begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= rsc_pkg::RSC_ASSERT;
        end else begin
            unique case (state)
                rsc_pkg::RSC_RUN: begin
                    if (any_cause) begin
                        state <= rsc_pkg::RSC_ASSERT;
                    end
                end
                // ASSERT waits for every cause to drop before the stretch starts
                rsc_pkg::RSC_ASSERT: begin
                    if (!any_cause) begin
                        state <= rsc_pkg::RSC_HOLD;
                    end
                end
                rsc_pkg::RSC_HOLD: begin
                    if (any_cause) begin
                        state <= rsc_pkg::RSC_ASSERT;
                    end else if (hold_cnt_done) begin
                        state <= rsc_pkg::RSC_RUN;
                    end
                end
                default: begin
                    state <= rsc_pkg::RSC_ASSERT;
                end
            endcase
        end
    end

    // one stretched level feeds every consumer, so none can leave reset early
    assign system_reset       = (state != rsc_pkg::RSC_RUN);
    assign peripheral_disable = system_reset;
    assign pins_to_reset_cfg  = system_reset;
    assign pc_load            = system_reset;

    // the vector is constant here; kept in a register so the core sees a settled value
    always_ff @(posedge mclk) begin
        if (rst) begin
            pc_reset_vector <= rsc_pkg::RESET_VECTOR;
        end else begin
            pc_reset_vector <= rsc_pkg::RESET_VECTOR;
        end
    end

    // status: power-on wipes older causes; a new cause beats a same-cycle clear
    logic [6:0] cause_now;
    logic [6:0] status_keep;
    assign cause_now   = cause;
    assign status_keep = reset_cause_status & ~status_clear;

    always_ff @(posedge mclk) begin
        if (rst) begin
            reset_cause_status <= rsc_pkg::STATUS_RESET;
        end else if (cause[rsc_pkg::CAUSE_POR]) begin
            reset_cause_status <= cause_now;
        end else begin
            reset_cause_status <= status_keep | cause_now;
        end
    end

    // the enable register is held at its reset value while reset is active
    always_ff @(posedge mclk) begin
        if (rst || system_reset) begin
            port_a_peripheral_enable <= rsc_pkg::PORTA_PER_INIT;
        end else if (porta_per_we) begin
            port_a_peripheral_enable <= porta_per_wdata;
        end
    end

    // pin drive: released whenever the reset function owns the pin
    always_ff @(posedge mclk) begin
        if (rst || pin_is_reset || system_reset) begin
            shared_pin_out  <= 1'b0;
            shared_pin_oe_n <= 1'b1;
        end else begin
            shared_pin_out  <= gpio_a7_out;
            shared_pin_oe_n <= ~gpio_a7_drive;
        end
    end

    // pull-up follows the reset function and stays on through any system reset,
    // so a released pin never floats while it can still reset the chip
    always_ff @(posedge mclk) begin
        if (rst || pin_is_reset || system_reset) begin
            shared_pin_pullup <= 1'b1;
        end else begin
            shared_pin_pullup <= 1'b0;
        end
    end

    // input path: the synchronised level reaches software only in gpio mode;
    // reads while the pin is the reset input return zero, not a stale level
    always_ff @(posedge mclk) begin
        if (rst || pin_is_reset || system_reset) begin
            gpio_a7_in <= 1'b0;
        end else begin
            gpio_a7_in <= pin_sync;
        end
    end
endmodule

// ### rsc_top_monitor.sv
// rsc_top_monitor: port-level checks of the reset source collector
// assumes it is bound to rsc_top and sees only its ports
`timescale 1ns/1ps
module rsc_top_monitor (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        power_on_reset,
    input wire logic        low_voltage_detect_reset,
    input wire logic        software_request_reset,
    input wire logic [6:0]  status_clear,
    input wire logic        shared_pin_oe_n,
    input wire logic        shared_pin_pullup,
    input wire logic [7:0]  port_a_peripheral_enable,
    input wire logic [6:0]  reset_cause_status,
    input wire logic        system_reset,
    input wire logic        peripheral_disable,
    input wire logic        pins_to_reset_cfg,
    input wire logic        pc_load,
    input wire logic [20:0] pc_reset_vector
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_sw; software_request_reset |=> system_reset && reset_cause_status[6]; endproperty
    a_sw: assert property (p_sw) else $error("sw cause missed");
    property p_or; low_voltage_detect_reset |-> ##[1:4] system_reset; endproperty
    a_or: assert property (p_or) else $error("lvd cause missed");
    property p_nocause; !reset_cause_status[6] && !software_request_reset |=> !reset_cause_status[6];
    endproperty
    a_nocause: assert property (p_nocause) else $error("status set without cause");
    property p_sticky; $fell(reset_cause_status[3]) |-> $past(status_clear[3])
        || $past(power_on_reset, 2) || $past(power_on_reset, 3); endproperty
    a_sticky: assert property (p_sticky) else $error("status lost");
    property p_mirror; (peripheral_disable == system_reset) && (pc_load == system_reset)
        && (pins_to_reset_cfg == system_reset); endproperty
    a_mirror: assert property (p_mirror) else $error("reset fanout wrong");
    property p_vec; pc_load |-> pc_reset_vector == rsc_pkg::RESET_VECTOR; endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    property p_en; system_reset [*2] |-> port_a_peripheral_enable == rsc_pkg::PORTA_PER_INIT;
    endproperty
    a_en: assert property (p_en) else $error("enable not restored");
    property p_pull; system_reset [*2] |-> shared_pin_pullup && shared_pin_oe_n; endproperty
    a_pull: assert property (p_pull) else $error("pull-up off in reset");
    cover property (software_request_reset);
    cover property (!port_a_peripheral_enable[7]);
    cover property ($fell(system_reset));
endmodule
bind rsc_top rsc_top_monitor mon (.mclk, .rst, .power_on_reset, .low_voltage_detect_reset,
    .software_request_reset, .status_clear, .shared_pin_oe_n, .shared_pin_pullup,
    .port_a_peripheral_enable, .reset_cause_status, .system_reset, .peripheral_disable,
    .pins_to_reset_cfg, .pc_load, .pc_reset_vector);

// ### rsc_top_test.sv
// rsc_top_test: directed checks of the reset source collector
// assumes rsc_top with HOLD=1 and the pin model on the shared pin
`timescale 1ns/1ps
module rsc_top_test;
    logic mclk = 0, rst = 1, we = 0, ext_low = 0, g_out = 0, g_drv = 0, pin, oe_n, pout;
    logic [5:0] cz = '0;
    logic [6:0] clr = '0, st, exp;
    logic [7:0] wd = '0, en;
    logic pull, gin, sr;
    int bad_count = 0, n_tests = 0, cyc = 0;
    int map [6] = '{0, 1, 2, 4, 5, 6};
    always #25 mclk = ~mclk;
    rsc_top #(.HOLD(1)) dut (.mclk(mclk), .rst(rst), .power_on_reset(cz[0]),
        .partial_power_down_reset(cz[1]), .low_voltage_detect_reset(cz[2]),
        .watchdog_lost_reference_reset(cz[3]), .watchdog_timeout_reset(cz[4]),
        .software_request_reset(cz[5]), .status_clear(clr), .porta_per_we(we),
        .porta_per_wdata(wd), .gpio_a7_out(g_out), .gpio_a7_drive(g_drv),
        .shared_pin_in(pin), .shared_pin_out(pout), .shared_pin_oe_n(oe_n),
        .shared_pin_pullup(pull), .gpio_a7_in(gin), .port_a_peripheral_enable(en),
        .reset_cause_status(st), .system_reset(sr), .peripheral_disable(), .pins_to_reset_cfg(),
        .pc_load(), .pc_reset_vector());
    rsc_pin_model pm (.mclk(mclk), .ext_low(ext_low), .pin_out(pout), .pin_oe_n(oe_n),
        .pull_on(pull), .pin(pin));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wait_sr(input logic v);
        for (int k = 0; k < 60 && sr !== v; k++) @(negedge mclk);
        chk("system_reset", {7'h00, v}, {7'h00, sr});
    endtask
    task automatic hit(input int i);
        @(posedge mclk) cz[i] <= 1'b1;
        wait_sr(1'b1);
        @(posedge mclk) cz[i] <= 1'b0;
        wait_sr(1'b0);
    endtask
    always @(posedge mclk) begin
        cyc++;
        // the whole sequence needs well under a thousand cycles
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        wait_sr(1'b0);
        chk("enable", 8'hFF, en);
        hit(0);
        chk("status", 8'h01, {1'b0, st});
        hit(1);
        chk("status", 8'h03, {1'b0, st});
        @(posedge mclk) clr <= 7'h7F;
        @(posedge mclk) clr <= 7'h00;
        @(negedge mclk) chk("status", 8'h00, {1'b0, st});
        exp = 7'h00;
        for (int i = 2; i < 6; i++) begin
            hit(i);
            exp[map[i]] = 1'b1;
            chk("status", {1'b0, exp}, {1'b0, st});
        end
        @(posedge mclk) ext_low <= 1'b1;
        wait_sr(1'b1);
        @(posedge mclk) ext_low <= 1'b0;
        wait_sr(1'b0);
        chk("status", {1'b0, exp | 7'h08}, {1'b0, st});
        chk("pullup", 8'h01, {7'h00, pull});
        $display("test causes done");
        @(posedge mclk) begin we <= 1'b1; wd <= 8'h7F; end
        @(posedge mclk) begin we <= 1'b0; g_drv <= 1'b1; g_out <= 1'b1; end
        repeat (3) @(negedge mclk);
        chk("enable", 8'h7F, en);
        chk("pin", 8'h01, {6'h00, oe_n, pout});
        chk("gpio_in", 8'h01, {7'h00, gin});
        chk("pullup", 8'h00, {7'h00, pull});
        @(posedge mclk) begin g_drv <= 1'b0; ext_low <= 1'b1; end
        repeat (6) @(negedge mclk);
        chk("reset", 8'h00, {6'h00, sr, gin});
        @(posedge mclk) ext_low <= 1'b0;
        @(posedge mclk) clr <= 7'h7F;
        @(posedge mclk) clr <= 7'h00;
        hit(5);
        chk("status", 8'h40, {1'b0, st});
        chk("enable", 8'hFF, en);
        chk("pullup", 8'h01, {7'h00, pull});
        $display("test gpio done");
        end_sim();
    end
endmodule
